// File: design/flow_trace_mark.sv
// program flow trace marking: classifies fetches, marks indirect flow changes, drives trace pins
// assumes the fetch unit presents one fetch event per cycle with its kind, synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module flow_trace_mark (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire flow_trace_pkg::fetch_s fetch,
    input wire flow_trace_pkg::fetch_kind_e fetch_kind,
    input wire logic context_instr,
    input wire logic [2:0] queue_flush_count,
    input wire logic [1:0] history_flush_count,
    input wire logic debug_mode,
    input wire logic sync_request,
    input wire logic show_write,
    input wire logic [1:0] show_write_value,
    input wire logic instr_issue,
    output flow_trace_pkg::bus_mark_s bus_mark,
    output logic [2:0] queue_status_lines,
    output logic [1:0] history_flush_lines,
    output logic fetch_serialize,
    output logic [1:0] fetch_show_control
);
    logic [1:0] pending_show;
    logic [1:0] pending_count;
    logic sync_seen;
    logic mark_next;
    logic direct_mark;
    logic next_direct_mark;
    logic flush_slot;
    logic [1:0] next_fetch_show_control;
    logic [1:0] next_pending_show;
    logic [1:0] next_pending_count;
    logic next_sync_seen;
    logic next_mark_next;
    logic next_flush_slot;
    flow_trace_pkg::bus_mark_s next_bus_mark;
    logic [2:0] next_queue_status;
    logic [1:0] next_history_flush;
    logic next_fetch_serialize;
    logic sync_toggle;
    logic indirect;
    logic flow_change;
    logic show_it;

    function automatic logic kind_flushes(input flow_trace_pkg::fetch_kind_e k);
        kind_flushes = k[2];
    endfunction

    // control pipeline: the write waits until two instructions have issued
    always_comb begin
        next_fetch_show_control = fetch_show_control;
        next_pending_show = pending_show;
        next_pending_count = pending_count;
        if (pending_count != 2'h0 && instr_issue) begin
            next_pending_count = pending_count - 2'h1;
            if (pending_count == 2'h1) begin
                next_fetch_show_control = pending_show;
            end
        end
        if (show_write) begin
            next_pending_show = show_write_value;
            next_pending_count = 2'h2;
        end
    end

    always_comb begin
        sync_toggle = sync_request != sync_seen;
        indirect = mark_next;
        // the direct-taken kind arrives a cycle before its target fetch, so it is held like the indirect mark
        flow_change = mark_next || direct_mark;
        next_sync_seen = sync_request;
        next_mark_next = mark_next;
        next_direct_mark = direct_mark;
        next_flush_slot = flush_slot;
        next_queue_status = flow_trace_pkg::QS_NONE;
        next_history_flush = history_flush_count;
        if (sync_toggle) begin
            next_mark_next = 1'b1;
        end
        if (fetch.valid) begin
            next_mark_next = sync_toggle;
            next_direct_mark = 1'b0;
        end
        if (fetch_kind == flow_trace_pkg::QS_DIRECT) begin
            next_direct_mark = 1'b1;
        end
        // the kind reported describes the previous fetch; its target gets the mark
        if (fetch_kind == flow_trace_pkg::QS_EXCEPTION || fetch_kind == flow_trace_pkg::QS_INDIRECT
                || context_instr) begin
            next_mark_next = 1'b1;
        end
        if (flush_slot && fetch_kind != flow_trace_pkg::QS_NOT_TAKEN_F) begin
            next_queue_status = queue_flush_count;
            next_flush_slot = 1'b0;
        end else if (context_instr) begin
            next_queue_status = flow_trace_pkg::QS_INDIRECT;
            next_flush_slot = 1'b1;
        end else if (sync_toggle && fetch_kind == flow_trace_pkg::QS_NONE) begin
            next_queue_status = flow_trace_pkg::QS_SYNC;
            next_flush_slot = 1'b0;
        end else begin
            next_queue_status = fetch_kind;
            next_flush_slot = kind_flushes(fetch_kind);
        end
        if (debug_mode) begin
            next_queue_status = flow_trace_pkg::QS_NONE;
            next_history_flush = flow_trace_pkg::FLUSH_DEBUG;
            next_flush_slot = 1'b0;
        end
        case (fetch_show_control)
            flow_trace_pkg::SHOW_ALL: show_it = 1'b1;
            flow_trace_pkg::SHOW_FLOW: show_it = flow_change;
            flow_trace_pkg::SHOW_INDIRECT: show_it = indirect;
            flow_trace_pkg::SHOW_SYNC: show_it = indirect && sync_request;
            default: show_it = 1'b0;
        endcase
        next_fetch_serialize = fetch_show_control == flow_trace_pkg::SHOW_ALL;
        next_bus_mark = '0;
        // retirement lives in the core; this block reports fetches only
        if (fetch.valid && show_it) begin
            next_bus_mark.show = 1'b1;
            next_bus_mark.address_type = 1'b1;
            if (fetch.internal || fetch.cache_hit) begin
                next_bus_mark.address_only = 1'b1;
                next_bus_mark.cycle_type = fetch.int_cycle_type;
                next_bus_mark.write_not_read = !indirect;
            end else begin
                next_bus_mark.cycle_type = indirect ? flow_trace_pkg::CT_INDIRECT_EXT
                                                    : flow_trace_pkg::CT_NORMAL;
                next_bus_mark.write_not_read = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fetch_show_control <= flow_trace_pkg::SHOW_RESET;
            pending_show <= flow_trace_pkg::SHOW_RESET;
            pending_count <= 2'h0;
            sync_seen <= 1'b0;
            mark_next <= 1'b0;
            direct_mark <= 1'b0;
            flush_slot <= 1'b0;
            bus_mark <= '0;
            queue_status_lines <= 3'h0;
            history_flush_lines <= 2'h0;
            fetch_serialize <= 1'b0;
        end else begin
            fetch_show_control <= next_fetch_show_control;
            pending_show <= next_pending_show;
            pending_count <= next_pending_count;
            sync_seen <= next_sync_seen;
            mark_next <= next_mark_next;
            direct_mark <= next_direct_mark;
            flush_slot <= next_flush_slot;
            bus_mark <= next_bus_mark;
            queue_status_lines <= next_queue_status;
            history_flush_lines <= next_history_flush;
            fetch_serialize <= next_fetch_serialize;
        end
    end

    AST_ALL_SERIAL: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch_show_control == flow_trace_pkg::SHOW_ALL |=> fetch_serialize)
        else $error("show-all not serialized");
    AST_EXT_MARK: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch.valid && show_it && indirect && !fetch.internal && !fetch.cache_hit
        |=> bus_mark.cycle_type == 4'h1 && bus_mark.write_not_read)
        else $error("external indirect fetch not coded 0001");
    AST_INT_MARK: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch.valid && show_it && indirect && fetch.internal |=> bus_mark.address_only && !bus_mark.write_not_read)
        else $error("internal indirect fetch not marked low");
    AST_AT_HIGH: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus_mark.show |-> bus_mark.address_type)
        else $error("address type low on show");
    AST_CTX_101: assert property (@(posedge ref_clk) disable iff (!resetn)
        context_instr && !flush_slot && !debug_mode |=> queue_status_lines == 3'b101 ##0 mark_next)
        else $error("context instruction not reported as indirect");
    AST_SYNC_MARK: assert property (@(posedge ref_clk) disable iff (!resetn)
        sync_request != sync_seen |=> mark_next)
        else $error("sync toggle not marked");
    AST_DELAY: assert property (@(posedge ref_clk) disable iff (!resetn)
        show_write && !instr_issue ##1 (!show_write && !instr_issue)[*2]
        |-> fetch_show_control == $past(fetch_show_control, 2))
        else $error("show control changed too early");
    AST_HIST: assert property (@(posedge ref_clk) disable iff (!resetn)
        !debug_mode |=> history_flush_lines == $past(history_flush_count))
        else $error("history flush count wrong");
    AST_NONE_SYNC: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch_show_control == 2'h3 && !sync_request |=> !bus_mark.show)
        else $error("show cycle while suppressed");
    AST_DEBUG_PINS: assert property (@(posedge ref_clk) disable iff (!resetn)
        debug_mode |=> queue_status_lines == 3'h0 && history_flush_lines == 2'h3)
        else $error("debug mode pins wrong");
    AST_SERIAL_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch_show_control != flow_trace_pkg::SHOW_ALL |=> !fetch_serialize)
        else $error("serialized outside show-all");
    AST_FLUSH_REPORT: assert property (@(posedge ref_clk) disable iff (!resetn)
        flush_slot && !debug_mode && fetch_kind != flow_trace_pkg::QS_NOT_TAKEN_F
        |=> queue_status_lines == $past(queue_flush_count))
        else $error("queue flush count not reported");
    AST_DIRECT_SHOW: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch_show_control == flow_trace_pkg::SHOW_FLOW && fetch.valid && direct_mark |=> bus_mark.show)
        else $error("direct flow change not shown");
    AST_EXT_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus_mark.show && !bus_mark.address_only |-> bus_mark.write_not_read)
        else $error("full external cycle without write-not-read high");
    AST_NO_FETCH: assert property (@(posedge ref_clk) disable iff (!resetn)
        !fetch.valid |=> !bus_mark.show)
        else $error("show cycle without a fetch");
    AST_ALL_SHOWN: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch_show_control == flow_trace_pkg::SHOW_ALL && fetch.valid |=> bus_mark.show)
        else $error("fetch not shown in show-all");
    COV_DIRECT: cover property (@(posedge ref_clk) fetch_show_control == flow_trace_pkg::SHOW_FLOW
        && direct_mark && fetch.valid ##1 bus_mark.show);
    COV_EXT: cover property (@(posedge ref_clk) bus_mark.show && bus_mark.cycle_type == 4'h1);
    COV_INT: cover property (@(posedge ref_clk) bus_mark.show && !bus_mark.write_not_read);
    COV_CTX: cover property (@(posedge ref_clk) context_instr ##1 queue_status_lines == 3'b101);
endmodule
`default_nettype wire

// File: common/flow_trace_pkg.sv
// constants and carrier types for the program flow trace marking block
// assumes a single processor clock and core reset
package flow_trace_pkg;
    localparam logic [1:0] SHOW_ALL = 2'h0;
    localparam logic [1:0] SHOW_FLOW = 2'h1;
    localparam logic [1:0] SHOW_INDIRECT = 2'h2;
    localparam logic [1:0] SHOW_SYNC = 2'h3;
    localparam logic [1:0] SHOW_RESET = 2'h3;
    localparam logic [3:0] CT_NORMAL = 4'h0;
    localparam logic [3:0] CT_INDIRECT_EXT = 4'h1;
    localparam logic [1:0] FLUSH_DEBUG = 2'h3;
    typedef enum logic [2:0] {
        QS_NONE = 3'b000,
        QS_SEQ = 3'b001,
        QS_NOT_TAKEN = 3'b010,
        QS_SYNC = 3'b011,
        QS_EXCEPTION = 3'b100,
        QS_INDIRECT = 3'b101,
        QS_DIRECT = 3'b110,
        QS_NOT_TAKEN_F = 3'b111
    } fetch_kind_e;
    typedef struct packed {
        logic valid;
        logic internal;
        logic cache_hit;
        logic [3:0] int_cycle_type;
    } fetch_s;
    typedef struct packed {
        logic show;
        logic [3:0] cycle_type;
        logic address_type;
        logic write_not_read;
        logic address_only;
    } bus_mark_s;
endpackage

// File: tb/trace_observer.sv
// far-side capture model: counts fetches that the block shows on the external bus
// assumes bus_mark is registered on ref_clk
`timescale 1ns/1ps
`default_nettype none
module trace_observer (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire flow_trace_pkg::bus_mark_s bus_mark,
    output logic [7:0] shown_count
);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shown_count <= 8'h00;
        end else if (bus_mark.show) begin
            shown_count <= shown_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for flow_trace_mark with a capture model on the bus side
// assumes the package is compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    flow_trace_pkg::fetch_s fetch = '0;
    flow_trace_pkg::fetch_kind_e fetch_kind = flow_trace_pkg::QS_NONE;
    logic context_instr = 1'b0;
    logic [2:0] queue_flush_count = 3'h2;
    logic [1:0] history_flush_count = 2'h0;
    logic debug_mode = 1'b0;
    logic sync_request = 1'b0;
    logic show_write = 1'b0;
    logic [1:0] show_write_value = 2'h0;
    logic instr_issue = 1'b0;
    flow_trace_pkg::bus_mark_s bus_mark;
    logic [2:0] queue_status_lines;
    logic [1:0] history_flush_lines;
    logic fetch_serialize;
    logic [1:0] fetch_show_control;
    logic [7:0] shown_count;
    logic [1:0] cur_ctrl = 2'h3;
    int failures = 0;
    int total_checks = 0;
    int exp_shown = 0;
    always #10 ref_clk = ~ref_clk;
    flow_trace_mark u_flow_trace_mark (.ref_clk, .resetn, .fetch, .fetch_kind, .context_instr,
        .queue_flush_count, .history_flush_count, .debug_mode, .sync_request, .show_write,
        .show_write_value, .instr_issue, .bus_mark, .queue_status_lines, .history_flush_lines,
        .fetch_serialize, .fetch_show_control);
    trace_observer u_trace_observer (.ref_clk, .resetn, .bus_mark, .shown_count);
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task idle();
        @(posedge ref_clk);
        fetch <= '0;
        fetch_kind <= flow_trace_pkg::QS_NONE;
        context_instr <= 1'b0;
        show_write <= 1'b0;
        instr_issue <= 1'b0;
    endtask
    task set_control(input logic [1:0] v);
        @(posedge ref_clk);
        show_write <= 1'b1;
        show_write_value <= v;
        @(posedge ref_clk);
        show_write <= 1'b0;
        instr_issue <= 1'b1;
        idle();
        idle();
        #1;
        check("old control", fetch_show_control, cur_ctrl);
        @(posedge ref_clk);
        instr_issue <= 1'b1;
        idle();
        idle();
        #1;
        check("control", fetch_show_control, v);
        idle();
        #1;
        check("serialize", fetch_serialize, v == 2'h0);
        cur_ctrl = v;
    endtask
    // kind (or context pulse) one cycle, then the fetch it marks
    task shown_fetch(input logic [2:0] k, input logic ctx, input logic [6:0] fs, input logic [7:0] exp,
        input logic full);
        @(posedge ref_clk);
        fetch_kind <= flow_trace_pkg::fetch_kind_e'(k);
        context_instr <= ctx;
        @(posedge ref_clk);
        fetch_kind <= flow_trace_pkg::QS_NONE;
        context_instr <= 1'b0;
        fetch <= fs;
        #1;
        check("queue kind", queue_status_lines, ctx ? 3'h5 : k);
        idle();
        #1;
        check("queue flush", queue_status_lines, (k[2] | ctx) ? 3'h2 : 3'h0);
        if (full) begin
            check("bus mark", bus_mark, exp);
        end else begin
            check("show", bus_mark.show, exp[7]);
        end
        if (exp[7]) begin
            exp_shown++;
        end
    endtask
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b0;
        @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        check("reset control", fetch_show_control, 8'h3);
        check("reset mark", bus_mark, 8'h00);
        shown_fetch(3'h5, 1'b0, 7'h40, 8'h00, 1'b0);
        @(posedge ref_clk);
        sync_request <= 1'b1;
        idle();
        #1;
        check("sync kind", queue_status_lines, 8'h3);
        shown_fetch(3'h0, 1'b0, 7'h40, {1'b1, flow_trace_pkg::CT_INDIRECT_EXT, 3'b110}, 1'b1);
        set_control(2'h2);
        shown_fetch(3'h5, 1'b0, 7'h40, {1'b1, flow_trace_pkg::CT_INDIRECT_EXT, 3'b110}, 1'b1);
        shown_fetch(3'h4, 1'b0, 7'h65, {1'b1, 4'h5, 3'b101}, 1'b1);
        shown_fetch(3'h1, 1'b1, 7'h59, {1'b1, 4'h9, 3'b101}, 1'b1);
        shown_fetch(3'h6, 1'b0, 7'h40, 8'h00, 1'b0);
        set_control(2'h1);
        shown_fetch(3'h6, 1'b0, 7'h40, 8'h80, 1'b0);
        set_control(2'h0);
        shown_fetch(3'h1, 1'b0, 7'h40, 8'h80, 1'b0);
        @(posedge ref_clk);
        debug_mode <= 1'b1;
        idle();
        #1;
        check("debug queue", queue_status_lines, 8'h0);
        check("debug history", history_flush_lines, 8'h3);
        @(posedge ref_clk);
        debug_mode <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            history_flush_count <= i[1:0];
            idle();
            #1;
            check("history", history_flush_lines, i[7:0]);
        end
        check("shown count", shown_count, exp_shown[7:0]);
        report_and_stop();
    end
endmodule
`default_nettype wire
